// >>> hdl/tcc_pkg.sv
// Package of constants and types for the 16-bit timer/capture block
package tcc_pkg;
	localparam int CNT_W = 16;
	localparam int PRE_W = 7;
	localparam logic [15:0] ADDR_PORT_LATCH = 16'hff00;
	localparam logic [15:0] ADDR_PORT_DIR = 16'hff20;
	localparam logic [15:0] ADDR_COUNT_LO = 16'hff10;
	localparam logic [15:0] ADDR_COUNT_HI = 16'hff11;
	localparam logic [15:0] ADDR_CCA_LO = 16'hff12;
	localparam logic [15:0] ADDR_CCA_HI = 16'hff13;
	localparam logic [15:0] ADDR_CCB_LO = 16'hff14;
	localparam logic [15:0] ADDR_CCB_HI = 16'hff15;
	localparam logic [15:0] ADDR_RUN_MODE = 16'hff60;
	localparam logic [15:0] ADDR_CLK_EDGE = 16'hff61;
	localparam logic [15:0] ADDR_CC_CTRL = 16'hff62;
	localparam logic [15:0] ADDR_OUT_CTRL = 16'hff63;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_PORT_DIR = 8'hff;
	// Bit positions
	localparam int RM_WRAP = 0;
	localparam int RM_EDGE_TOG = 1;
	localparam int RM_LO = 2;
	localparam int RM_HI = 3;
	localparam int CC_A_CAP = 0;
	localparam int CC_A_TRIG = 1;
	localparam int CC_B_CAP = 2;
	localparam int OC_PIN_EN = 0;
	localparam int OC_TOG_A = 1;
	localparam int OC_CLEAR = 2;
	localparam int OC_SET = 3;
	localparam int OC_TOG_B = 4;
	localparam int CS_LO = 0;
	localparam int IN0_EDGE_LO = 4;
	localparam int IN1_EDGE_LO = 6;
	localparam int SHARED_PIN = 5;
	// Divider exponents of the count clock choices
	localparam int DIV_EXP_0 = 1;
	localparam int DIV_EXP_1 = 4;
	localparam int DIV_EXP_2 = 7;
	localparam logic [1:0] CLK_SEL_EDGE = 2'h3;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	typedef enum logic [1:0] {
		RM_STOP,
		RM_FREE,
		RM_CLR_EDGE,
		RM_CLR_MATCH
	} tcc_run_e;
endpackage

// >>> hdl/tcc_filt_if.sv
// Interface between the timer core and its input noise filters
`timescale 1ns/1ps
interface tcc_filt_if;
	logic tick;
	logic level;
	logic rise;
	logic fall;
	modport filt (
		input tick,
		output level,
		output rise,
		output fall
	);
	modport core (
		output tick,
		input level,
		input rise,
		input fall
	);
endinterface

// >>> hdl/tcc_in_filter.sv
// Pin synchroniser and two-sample noise filter for one timer input
`timescale 1ns/1ps
module tcc_in_filter import tcc_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Raw pin
	input wire logic pin,
	// Core side
	tcc_filt_if.filt f
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic samp;
		logic lvl;
		logic rise;
		logic fall;
	} tcc_filt_s;

	tcc_filt_s q;
	tcc_filt_s d;

	always_comb begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.rise = 1'b0;
		d.fall = 1'b0;
		if (f.tick) begin
			d.samp = q.s2;
			// New level needs two equal samples before it is taken
			if (q.s2 == q.samp && q.s2 != q.lvl) begin
				d.lvl = q.s2;
				d.rise = q.s2;
				d.fall = ~q.s2;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign f.level = q.lvl;
	assign f.rise = q.rise;
	assign f.fall = q.fall;

	chk_filter_two_samples: assert property (@(posedge core_clk)
		disable iff (reset) (q.rise || q.fall) |-> $past(q.s2 == q.samp))
		else $error("filter edge without two equal samples");
endmodule

// >>> hdl/tcc_timer.sv
// Top of the 16-bit timer with two capture/compare registers
`timescale 1ns/1ps
// Functional notes
// - Run mode: stop, free, edge clear, match clear
// - Count advances each count clock unless stopped
// - Compare equality raises that register's request
// - Capture only after two equal input samples
// - Match clear with A=FFFF sets wrap flag
// - Register B compare at 0, capture at 1
// - A trigger: input 1 edge, or opposite input 0
// - Register A compare at 0, capture at 1
// - Both-edge input 0 with trigger 1: no capture
// - Match B toggles output when enabled
// - Match A toggles output when enabled
// - Set/clear pair: 00 keep, 01 clear, 10 set
// - Set and clear bits always read zero
// - Pin enable selects output flip-flop over port
// - Input 1 edge: falling, rising, both
// - Input 0 edge: falling, rising, both
// - Count clock: fx/2, fx/16, fx/128, input 0
// - Interval: clear on match A, keep counting, request
// - Interval period is N+1 count clocks
// - Reset clears control registers, direction to FF
module tcc_timer import tcc_pkg::*; #(
	parameter int COUNT_W = CNT_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register port
	input wire logic [15:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	// Timer pins
	input wire logic timer_input_0,
	input wire logic timer_input_1,
	output logic timer_output_pin_o,
	output logic timer_output_pin_oe,
	// Interrupt requests, one-cycle pulses
	output logic match_a_irq,
	output logic match_b_irq
);
	if (COUNT_W != 16) begin : g_bad_width
		$error("byte-wide register port serves a 16-bit counter only");
	end

	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [COUNT_W-1:0] count;
		logic [COUNT_W-1:0] cc_a;
		logic [COUNT_W-1:0] cc_b;
		logic [3:0] run_mode_control;
		logic [2:0] cc_control;
		logic [4:0] out_control;
		logic [7:0] clock_edge_select;
		logic [7:0] port_direction;
		logic [7:0] port_latch;
		logic out_ff;
		logic [7:0] rd_data;
		logic pin_o;
		logic pin_oe;
		logic irq_a;
		logic irq_b;
	} tcc_state_s;

	tcc_state_s q;
	tcc_state_s d;

	tcc_filt_if f0 ();
	tcc_filt_if f1 ();

	tcc_in_filter u_filt0 (
		.core_clk(core_clk),
		.reset(reset),
		.pin(timer_input_0),
		.f(f0.filt)
	);

	tcc_in_filter u_filt1 (
		.core_clk(core_clk),
		.reset(reset),
		.pin(timer_input_1),
		.f(f1.filt)
	);

	// True when the low bits of the prescaler are all ones
	function automatic logic div_tick(logic [PRE_W-1:0] p, int unsigned e);
		logic [PRE_W-1:0] mask;
		mask = PRE_W'((1 << e) - 1);
		return (p & mask) == mask;
	endfunction

	function automatic logic valid_edge(logic [1:0] sel, logic r, logic f);
		logic v;
		v = 1'b0;
		case (sel)
			EDGE_FALL: v = f;
			EDGE_RISE: v = r;
			EDGE_BOTH: v = r | f;
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	logic [1:0] clk_sel;
	logic [1:0] in0_edge;
	logic [1:0] in1_edge;
	tcc_run_e run;
	logic running;
	logic pre_tick;
	logic count_tick;
	logic in0_valid;
	logic in1_valid;
	logic in0_opposite;
	logic cmp_a_hit;
	logic cmp_b_hit;
	logic cap_a;
	logic cap_b;
	logic toggle;

	assign clk_sel = q.clock_edge_select[CS_LO+1:CS_LO];
	assign in0_edge = q.clock_edge_select[IN0_EDGE_LO+1:IN0_EDGE_LO];
	assign in1_edge = q.clock_edge_select[IN1_EDGE_LO+1:IN1_EDGE_LO];
	assign run = tcc_run_e'(q.run_mode_control[RM_HI:RM_LO]);
	assign running = run != RM_STOP;
	always_comb begin
		case (clk_sel)
			2'h0: pre_tick = div_tick(q.pre, DIV_EXP_0);
			2'h1: pre_tick = div_tick(q.pre, DIV_EXP_1);
			2'h2: pre_tick = div_tick(q.pre, DIV_EXP_2);
			default: pre_tick = div_tick(q.pre, DIV_EXP_0);
		endcase
	end
	assign count_tick = (clk_sel == CLK_SEL_EDGE) ? in0_valid : pre_tick;
	assign f0.tick = pre_tick;
	assign f1.tick = pre_tick;
	assign in0_valid = valid_edge(in0_edge, f0.rise, f0.fall);
	assign in1_valid = valid_edge(in1_edge, f1.rise, f1.fall);
	// Opposite phase of the input 0 edge; none when both edges are valid
	assign in0_opposite = (in0_edge == EDGE_FALL) ? f0.rise :
		(in0_edge == EDGE_RISE) ? f0.fall : 1'b0;
	assign cmp_a_hit = running && count_tick &&
		!q.cc_control[CC_A_CAP] && q.count == q.cc_a;
	assign cmp_b_hit = running && count_tick &&
		!q.cc_control[CC_B_CAP] && q.count == q.cc_b;
	assign cap_a = q.cc_control[CC_A_CAP] &&
		(q.cc_control[CC_A_TRIG] ? in0_opposite : in1_valid);
	assign cap_b = q.cc_control[CC_B_CAP] && in0_valid;
	// Simultaneous inversions cancel in pairs; three of them still invert
	assign toggle = (q.out_control[OC_TOG_A] & cmp_a_hit) ^
		(q.out_control[OC_TOG_B] & cmp_b_hit) ^
		(q.run_mode_control[RM_EDGE_TOG] & running & in0_valid);

	always_comb begin
		d = q;
		d.pre = q.pre + 1'b1;
		d.rd_data = RST_ZERO;
		d.irq_a = cmp_a_hit | cap_a;
		d.irq_b = cmp_b_hit | cap_b;
		// Counter
		if (!running) begin
			d.count = '0;
		end else begin
			if (count_tick) begin
				if (run == RM_CLR_MATCH && q.count == q.cc_a) begin
					d.count = '0;
				end else begin
					d.count = q.count + 1'b1;
				end
			end
			if (run == RM_CLR_EDGE && in0_valid) begin
				d.count = '0;
			end
		end
		// Captures take the count seen when the filter confirms
		if (cap_a) begin
			d.cc_a = q.count;
		end
		if (cap_b) begin
			d.cc_b = q.count;
		end
		if (toggle) begin
			d.out_ff = ~q.out_ff;
		end
		// Register writes
		if (wr_en) begin
			case (addr)
				ADDR_PORT_LATCH: d.port_latch = wr_data;
				ADDR_PORT_DIR: d.port_direction = wr_data;
				ADDR_CCA_LO: if (!cap_a) d.cc_a[7:0] = wr_data;
				ADDR_CCA_HI: if (!cap_a) d.cc_a[15:8] = wr_data;
				ADDR_CCB_LO: if (!cap_b) d.cc_b[7:0] = wr_data;
				ADDR_CCB_HI: if (!cap_b) d.cc_b[15:8] = wr_data;
				ADDR_RUN_MODE: d.run_mode_control = wr_data[3:0];
				ADDR_CLK_EDGE: d.clock_edge_select = wr_data;
				ADDR_CC_CTRL: d.cc_control = wr_data[2:0];
				ADDR_OUT_CTRL: begin
					d.out_control = wr_data[4:0];
					case ({wr_data[OC_SET], wr_data[OC_CLEAR]})
						2'b01: d.out_ff = 1'b0;
						2'b10: d.out_ff = 1'b1;
						default: d.out_ff = toggle ^ q.out_ff;
					endcase
				end
				default: ;
			endcase
		end
		// Wrap flag: hardware set wins over a software write
		if (running && count_tick && q.count == '1) begin
			d.run_mode_control[RM_WRAP] = 1'b1;
		end
		// Read data stands in the cycle after the strobe
		if (rd_en) begin
			case (addr)
				ADDR_PORT_LATCH: d.rd_data = q.port_latch;
				ADDR_PORT_DIR: d.rd_data = q.port_direction;
				ADDR_COUNT_LO: d.rd_data = q.count[7:0];
				ADDR_COUNT_HI: d.rd_data = q.count[15:8];
				ADDR_CCA_LO: d.rd_data = q.cc_a[7:0];
				ADDR_CCA_HI: d.rd_data = q.cc_a[15:8];
				ADDR_CCB_LO: d.rd_data = q.cc_b[7:0];
				ADDR_CCB_HI: d.rd_data = q.cc_b[15:8];
				ADDR_RUN_MODE: d.rd_data = {4'h0, q.run_mode_control};
				ADDR_CLK_EDGE: d.rd_data = q.clock_edge_select;
				ADDR_CC_CTRL: d.rd_data = {5'h00, q.cc_control};
				ADDR_OUT_CTRL: d.rd_data = {3'h0, q.out_control[OC_TOG_B],
					2'h0, q.out_control[OC_TOG_A:OC_PIN_EN]};
				default: d.rd_data = RST_ZERO;
			endcase
		end
		// Shared pin: timer output or port latch, enabled by direction
		d.pin_o = d.out_control[OC_PIN_EN] ? d.out_ff :
			d.port_latch[SHARED_PIN];
		d.pin_oe = ~d.port_direction[SHARED_PIN];
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			q <= '0;
			q.port_direction <= RST_PORT_DIR;
		end else begin
			q <= d;
		end
	end

	assign rd_data = q.rd_data;
	assign timer_output_pin_o = q.pin_o;
	assign timer_output_pin_oe = q.pin_oe;
	assign match_a_irq = q.irq_a;
	assign match_b_irq = q.irq_b;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	chk_stop_clears: assert property (
		run == RM_STOP |=> q.count == '0)
		else $error("counter not cleared in stop mode");
	chk_count_advance: assert property (
		running && count_tick && run != RM_CLR_MATCH && run != RM_CLR_EDGE
		|=> q.count == $past(q.count) + 16'h0001)
		else $error("counter did not advance on count clock");
	chk_match_a_irq: assert property (
		cmp_a_hit |=> match_a_irq)
		else $error("match A request missing");
	chk_interval_clear: assert property (
		run == RM_CLR_MATCH && cmp_a_hit && !in0_valid
		|=> q.count == '0 && match_a_irq)
		else $error("interval clear on match A failed");
	chk_wrap_flag: assert property (
		running && count_tick && q.count == 16'hffff
		|=> q.run_mode_control[RM_WRAP])
		else $error("wrap flag not set at rollover");
	chk_capture_b: assert property (
		cap_b |=> q.cc_b == $past(q.count) && match_b_irq)
		else $error("capture into register B wrong");
	chk_no_capture_both: assert property (
		q.cc_control[CC_A_CAP] && q.cc_control[CC_A_TRIG] &&
		in0_edge == EDGE_BOTH |-> !cap_a)
		else $error("register A captured with both-edge trigger");
	chk_setclr_read: assert property (
		rd_en && addr == ADDR_OUT_CTRL |=> rd_data[OC_SET:OC_CLEAR] == 2'h0)
		else $error("set and clear bits read nonzero");
	chk_set_out: assert property (
		wr_en && addr == ADDR_OUT_CTRL && wr_data[OC_SET:OC_CLEAR] == 2'b10
		|=> q.out_ff)
		else $error("output flip-flop not set");
	chk_pin_drive: assert property (
		q.out_control[OC_PIN_EN] && !$changed(q.out_control)
		|=> timer_output_pin_o == $past(q.out_ff, 1) ||
		$changed(q.out_ff) || $changed(q.out_control))
		else $error("pin does not follow output flip-flop");
	chk_pin_oe_dir: assert property (
		timer_output_pin_oe == !q.port_direction[SHARED_PIN])
		else $error("pin enable does not follow direction bit");
	chk_port_mode: assert property (
		!q.out_control[OC_PIN_EN] |-> timer_output_pin_o == q.port_latch[SHARED_PIN])
		else $error("disabled timer output does not show port latch");

	// Output flip-flop: changes only on a toggle or a software write
	chk_out_toggle: assert property (
		toggle && !(wr_en && addr == ADDR_OUT_CTRL)
		|=> q.out_ff != $past(q.out_ff))
		else $error("output flip-flop did not invert");
	chk_out_hold: assert property (
		!toggle && !(wr_en && addr == ADDR_OUT_CTRL)
		|=> $stable(q.out_ff))
		else $error("output flip-flop changed without cause");
	chk_clear_out: assert property (
		wr_en && addr == ADDR_OUT_CTRL && wr_data[OC_SET:OC_CLEAR] == 2'b01
		|=> !q.out_ff)
		else $error("output flip-flop not cleared");

	// Counter, compare and capture paths
	chk_count_hold: assert property (
		running && !count_tick && !(run == RM_CLR_EDGE && in0_valid)
		|=> $stable(q.count))
		else $error("counter moved without a count clock");
	chk_edge_clear: assert property (
		run == RM_CLR_EDGE && in0_valid |=> q.count == '0)
		else $error("counter not cleared on input 0 edge");
	chk_match_b_irq: assert property (
		cmp_b_hit |=> match_b_irq)
		else $error("match B request missing");
	chk_capture_a: assert property (
		cap_a |=> q.cc_a == $past(q.count) && match_a_irq)
		else $error("capture into register A wrong");
	chk_trigger_a_in1: assert property (
		q.cc_control[CC_A_CAP] && !q.cc_control[CC_A_TRIG] && in1_valid
		|=> match_a_irq)
		else $error("register A missed input 1 trigger");
	chk_trigger_a_in0: assert property (
		q.cc_control[CC_A_CAP] && q.cc_control[CC_A_TRIG] &&
		in0_edge == EDGE_RISE && f0.fall |=> match_a_irq)
		else $error("register A missed opposite input 0 edge");

	cov_interval: cover property (cmp_a_hit && run == RM_CLR_MATCH);
	cov_capture_a: cover property (cap_a);
	cov_toggle: cover property (toggle ##1 timer_output_pin_oe);
	cov_capture_b: cover property (cap_b);
	cov_edge_clear: cover property (run == RM_CLR_EDGE && in0_valid);
endmodule

// >>> verification/tcc_pulse_src.sv
// Model of the external pulse sources on the two timer inputs
`timescale 1ns/1ps
module tcc_pulse_src (
	// Clock
	input wire logic core_clk,
	// Timer input pins
	output logic in0,
	output logic in1
);
	initial begin
		in0 = 1'b0;
		in1 = 1'b0;
	end
	// One high pulse of width cycles on the chosen input, then back low
	task automatic pulse(input int ch, input int width);
		@(posedge core_clk);
		if (ch == 0) begin
			in0 <= 1'b1;
		end else begin
			in1 <= 1'b1;
		end
		repeat (width) @(posedge core_clk);
		if (ch == 0) begin
			in0 <= 1'b0;
		end else begin
			in1 <= 1'b0;
		end
	endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the 16-bit timer with capture/compare
`timescale 1ns/1ps
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module testbench import tcc_pkg::*; ;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic in0;
	logic in1;
	logic pin_o;
	logic pin_oe;
	logic irq_a;
	logic irq_b;
	int n_mismatch = 0;
	int total_checks = 0;
	int cnt_a = 0;
	int cnt_b = 0;
	int p;
	logic [7:0] d0;
	logic [7:0] d1;
	logic [7:0] oc [5] = '{8'h05, 8'h00, 8'h09, 8'h01, 8'h05};
	logic pv [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
	logic [15:0] nv [3] = '{16'h0000, 16'h0003, 16'h0105};
	int ex [3] = '{DIV_EXP_0, DIV_EXP_1, DIV_EXP_2};
	tcc_timer uut (
		.core_clk(core_clk),
		.reset(reset),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.timer_input_0(in0),
		.timer_input_1(in1),
		.timer_output_pin_o(pin_o),
		.timer_output_pin_oe(pin_oe),
		.match_a_irq(irq_a),
		.match_b_irq(irq_b)
	);
	tcc_pulse_src src (
		.core_clk(core_clk),
		.in0(in0),
		.in1(in1)
	);
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cnt_a += int'(irq_a === 1'b1);
		cnt_b += int'(irq_b === 1'b1);
	end
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
		@(posedge core_clk);
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask
	// Counts cycles until the chosen request pulses, bounded
	task automatic wait_irq(input int which, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (n < 2000 && ((which != 0) ? irq_b : irq_a) !== 1'b1);
	endtask
	// Stop, program controls, park both compare values out of reach
	task automatic cfg(input logic [7:0] ce, input logic [7:0] cc,
			input logic [7:0] o);
		int i;
		wr(ADDR_RUN_MODE, 8'h00);
		wr(ADDR_CLK_EDGE, ce);
		wr(ADDR_CC_CTRL, cc);
		wr(ADDR_OUT_CTRL, o);
		for (i = 0; i < 4; i++) begin
			wr(ADDR_CCA_LO + 16'(i), 8'hff);
		end
	endtask
	// Requests seen while the pulse is high, then in total after it
	task automatic edge_run(input int ch, input int w, input logic [7:0] ce,
			input logic [7:0] cc, input logic [7:0] eh,
			input logic [7:0] el);
		cfg(ce, cc, 8'h00);
		wr(ADDR_RUN_MODE, 8'h04);
		cnt_a = 0;
		cnt_b = 0;
		src.pulse(ch, w);
		#1;
		`CHK(8'(cnt_a * 16 + cnt_b), eh)
		repeat (16) @(posedge core_clk);
		#1;
		`CHK(8'(cnt_a * 16 + cnt_b), el)
	endtask
	initial begin
		repeat (30000) @(posedge core_clk);
		n_mismatch++;
		report_and_stop();
	end
	initial begin : main
		int k;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		rdchk(ADDR_PORT_DIR, RST_PORT_DIR);
		rdchk(ADDR_CLK_EDGE, RST_ZERO);
		rdchk(ADDR_CC_CTRL, RST_ZERO);
		rdchk(ADDR_OUT_CTRL, RST_ZERO);
		`CHK(pin_oe, 1'b0)
		wr(16'hff7f, 8'h5a);
		rdchk(16'hff7f, 8'h00);
		wr(ADDR_PORT_DIR, 8'hdf);
		wr(ADDR_PORT_LATCH, 8'h20);
		for (k = 0; k < 5; k++) begin
			wr(ADDR_OUT_CTRL, oc[k]);
			#1;
			`CHK(pin_o, pv[k])
			rdchk(ADDR_OUT_CTRL, oc[k] & 8'hf3);
		end
		`CHK(pin_oe, 1'b1)
		edge_run(0, 16, 8'h00, 8'h04, 8'h00, 8'h01);
		edge_run(0, 16, 8'h10, 8'h04, 8'h01, 8'h01);
		edge_run(0, 16, 8'h30, 8'h04, 8'h01, 8'h02);
		edge_run(0, 16, 8'h20, 8'h04, 8'h00, 8'h00);
		edge_run(0, 1, 8'h10, 8'h04, 8'h00, 8'h00);
		edge_run(0, 16, 8'h10, 8'h00, 8'h00, 8'h00);
		edge_run(1, 16, 8'h00, 8'h01, 8'h00, 8'h10);
		edge_run(1, 16, 8'h40, 8'h01, 8'h10, 8'h10);
		edge_run(1, 16, 8'hc0, 8'h01, 8'h10, 8'h20);
		edge_run(1, 16, 8'h80, 8'h01, 8'h00, 8'h00);
		edge_run(1, 16, 8'h40, 8'h00, 8'h00, 8'h00);
		edge_run(0, 16, 8'h10, 8'h03, 8'h00, 8'h10);
		edge_run(0, 16, 8'h30, 8'h03, 8'h00, 8'h00);
		foreach (nv[k]) begin
			cfg(8'h00, 8'h00, 8'h03);
			wr(ADDR_CCA_LO, nv[k][7:0]);
			wr(ADDR_CCA_HI, nv[k][15:8]);
			wr(ADDR_RUN_MODE, 8'h0c);
			wait_irq(0, p);
			d0 = {7'h00, pin_o};
			wait_irq(0, p);
			`CHK(p, (int'(nv[k]) + 1) << DIV_EXP_0)
			`CHK(pin_o, ~d0[0])
		end
		for (k = 0; k < 2; k++) begin
			cfg(8'h00, 8'h00, 8'h05 | 8'(k << OC_TOG_B));
			wr(ADDR_CCB_LO, 8'h05);
			wr(ADDR_CCB_HI, 8'h00);
			wr(ADDR_RUN_MODE, 8'h04);
			wait_irq(1, p);
			`CHK((p > 8) && (p < 20), 1'b1)
			repeat (2) @(posedge core_clk);
			#1;
			`CHK(pin_o, k[0])
		end
		for (k = 0; k < 3; k++) begin
			cfg(8'(k), 8'h00, 8'h00);
			wr(ADDR_RUN_MODE, 8'h04);
			rd(ADDR_COUNT_LO, d0);
			repeat ((4 << ex[k]) - 2) @(posedge core_clk);
			rd(ADDR_COUNT_LO, d1);
			`CHK(8'(d1 - d0), 8'h04)
		end
		wr(ADDR_RUN_MODE, 8'h00);
		rdchk(ADDR_COUNT_LO, 8'h00);
		cfg(8'h13, 8'h00, 8'h00);
		wr(ADDR_RUN_MODE, 8'h04);
		repeat (3) begin
			src.pulse(0, 16);
			repeat (16) @(posedge core_clk);
		end
		rdchk(ADDR_COUNT_LO, 8'h03);
		cfg(8'h10, 8'h00, 8'h00);
		wr(ADDR_RUN_MODE, 8'h08);
		repeat (100) @(posedge core_clk);
		src.pulse(0, 16);
		rd(ADDR_COUNT_LO, d0);
		`CHK(d0 < 8'h10, 1'b1)
		report_and_stop();
	end
endmodule
